// ---- core/mscfg_map.svh ----
// register offsets, field positions, reset values and timing figures of the start-up configuration bank
`ifndef MSCFG_MAP_SVH
`define MSCFG_MAP_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define MSCFG_ADDR_CONST_ADV 8'h91
`define MSCFG_ADDR_START_BRAKE 8'h92
`define MSCFG_RESET_CONST_ADV 16'h0000
`define MSCFG_RESET_START_BRAKE 16'h0000
// bit 15 reserved, bits 14:0 writable
`define MSCFG_CONST_ADV_WMASK 16'h7FFF

// ------------------------------------------------------------
// field positions of the constant and advance register
// ------------------------------------------------------------
`define MSCFG_KSH_MSB 14
`define MSCFG_KSH_LSB 12
`define MSCFG_KVAL_MSB 11
`define MSCFG_KVAL_LSB 8
`define MSCFG_ADVMODE_BIT 7
`define MSCFG_ASH_MSB 6
`define MSCFG_ASH_LSB 4
`define MSCFG_AVAL_MSB 3
`define MSCFG_AVAL_LSB 0

// ------------------------------------------------------------
// field positions of the start and brake register
// ------------------------------------------------------------
`define MSCFG_STJ_MSB 15
`define MSCFG_STJ_LSB 14
`define MSCFG_BRKCUR_BIT 13
`define MSCFG_HYS_BIT 12
`define MSCFG_ISD_BIT 11
`define MSCFG_REV_BIT 10
`define MSCFG_REVTHR_MSB 9
`define MSCFG_REVTHR_LSB 8
`define MSCFG_OLCUR_MSB 7
`define MSCFG_OLCUR_LSB 6
`define MSCFG_RAMP_MSB 5
`define MSCFG_RAMP_LSB 3
`define MSCFG_BRK_MSB 2
`define MSCFG_BRK_LSB 0

// ------------------------------------------------------------
// timing figures
// ------------------------------------------------------------
`define MSCFG_CLK_MHZ 50
`define MSCFG_STJ_BASE_MS 80
`define MSCFG_BRK_SLOWEST_MS 2700

`endif

// ---- core/mscfg_pkg.sv ----
// types shared by the start-up configuration bank
package mscfg_pkg;

    // register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } mscfg_req_t;

    // decoded constant and advance settings
    typedef struct packed {
        logic [2:0] bemf_const_shift;
        logic [3:0] bemf_const_value;
        logic advance_mode_select;
        logic [2:0] advance_time_shift;
        logic [3:0] advance_time_value;
    } mscfg_adv_t;

    // decoded start and brake settings
    typedef struct packed {
        logic [1:0] stationary_judge_threshold;
        logic brake_current_threshold_select;
        logic comparator_hysteresis_select;
        logic initial_speed_detect_enable;
        logic reverse_drive_enable;
        logic [1:0] reverse_brake_speed_threshold;
        logic [1:0] open_loop_current_level;
        logic [2:0] open_loop_current_ramp;
        logic [2:0] brake_time_select;
    } mscfg_start_t;

    // register port states
    typedef enum logic [2:0] {
        MSCFG_IDLE = 3'b001,
        MSCFG_WRITE = 3'b010,
        MSCFG_READ = 3'b100
    } mscfg_state_t;

endpackage

// ---- core/mscfg_shift.sv ----
// shift-and-value scaler: value placed left by shift
`timescale 1ns/1ps
module mscfg_shift #(
    parameter int VW = 4,
    parameter int SW = 3,
    parameter int OW = 11
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [VW-1:0] value,
    input wire logic [SW-1:0] shift,
    output logic [OW-1:0] scaled
);
    // ------------------------------------------------------------
    // registered scaling
    // ------------------------------------------------------------
    wire logic [OW-1:0] next_scaled = OW'(value) << shift;

    // registered so the output is glitch free
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            scaled <= '0;
        end else begin
            scaled <= next_scaled;
        end
    end

    // one cycle after an input change the result follows
    scale_follow_a: assert property (@(posedge core_clk) disable iff (!rstn)
        scaled == $past(next_scaled)) else $error("scaled output lags its inputs");
endmodule

// ---- core/mscfg_regs.sv ----
// start-up configuration bank: constant/advance and start/brake registers
//
// What this block does
// R1 - constant-and-advance register at 0x91, resets to zero
// R2 - bit 15 of that register is reserved and reads zero
// R3 - back-EMF constant is value bits 11:8 shifted left by bits 14:12
// R4 - advance-mode zero keeps advance at a fixed time
// R5 - advance-mode one scales advance by (supply minus back-EMF) over supply
// R6 - advance time is bits 3:0 shifted left by bits 6:4
// R7 - start-and-brake register at 0x92, resets to zero, fully writable
// R8 - bits 15:14 pick stationary threshold, 80 ms doubling to 640 ms
// R9 - bit 13 picks brake current threshold, 24 or 48 mA
// R10 - bit 12 picks comparator hysteresis, low or high
// R11 - bit 11 enables initial speed detection
// R12 - bit 10 enables reverse drive
// R13 - bits 9:8 pick reverse/brake start speed
// R14 - bits 7:6 pick open-loop current
// R15 - bits 7:6 also pick align current
// R16 - bits 5:3 pick open-loop current ramp rate
// R17 - bits 2:0 pick brake time, zero disables the brake
// R18 - reserved bits ignore writes and read as zero
`timescale 1ns/1ps
`include "mscfg_map.svh"
module mscfg_regs #(
    parameter int SUPPLY_W = 10,
    parameter int STJ_BASE_CYCLES = `MSCFG_STJ_BASE_MS * 1000 * `MSCFG_CLK_MHZ,
    parameter int BRK_SLOW_CYCLES = `MSCFG_BRK_SLOWEST_MS * 1000 * `MSCFG_CLK_MHZ
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire mscfg_pkg::mscfg_req_t req,
    input wire logic [SUPPLY_W-1:0] supply_level,
    input wire logic [SUPPLY_W-1:0] bemf_level,
    output logic [15:0] rdata,
    output logic rvalid,
    output logic ack,
    output mscfg_pkg::mscfg_adv_t adv_cfg,
    output mscfg_pkg::mscfg_start_t start_cfg,
    output logic [10:0] bemf_const,
    output logic [10:0] advance_time,
    output logic [10:0] advance_time_eff,
    output logic brake_active,
    output logic [31:0] stationary_cycles,
    output logic [31:0] brake_cycles,
    output logic [7:0] bank_state
);
    // ------------------------------------------------------------
    // storage and register port
    // ------------------------------------------------------------
    logic [15:0] motor_constant_advance_config;
    logic [15:0] startup_brake_config;
    mscfg_pkg::mscfg_state_t state;
    mscfg_pkg::mscfg_state_t next_state;

    wire logic hit_adv = req.addr == `MSCFG_ADDR_CONST_ADV;
    wire logic hit_start = req.addr == `MSCFG_ADDR_START_BRAKE;
    // R18 reserved bits dropped
    wire logic [15:0] wdata_adv = req.wdata & `MSCFG_CONST_ADV_WMASK;
    wire logic [15:0] read_mux = hit_adv ? motor_constant_advance_config :
                                 hit_start ? startup_brake_config : 16'h0000;

    // write has priority when both strobes are raised
    always_comb begin
        next_state = mscfg_pkg::MSCFG_IDLE;
        case (1'b1)
            req.wr: next_state = mscfg_pkg::MSCFG_WRITE;
            req.rd: next_state = mscfg_pkg::MSCFG_READ;
            default: next_state = mscfg_pkg::MSCFG_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state <= mscfg_pkg::MSCFG_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // R1 constant register reset
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            motor_constant_advance_config <= `MSCFG_RESET_CONST_ADV;
        end else if (req.wr && hit_adv) begin
            motor_constant_advance_config <= wdata_adv;
        end
    end

    // R7 start register fully writable
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            startup_brake_config <= `MSCFG_RESET_START_BRAKE;
        end else if (req.wr && hit_start) begin
            startup_brake_config <= req.wdata;
        end
    end

    // unmapped reads answer zero, not an error
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rdata <= 16'h0000;
            rvalid <= 1'b0;
            ack <= 1'b0;
        end else begin
            rdata <= (req.rd && !req.wr) ? read_mux : rdata;
            rvalid <= req.rd && !req.wr;
            ack <= req.rd || req.wr;
        end
    end

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    mscfg_pkg::mscfg_adv_t next_adv;
    mscfg_pkg::mscfg_start_t next_start;
    logic [31:0] next_stationary;
    logic [31:0] next_brake;

    // R2 reserved bit never reaches the fields
    assign next_adv.bemf_const_shift = motor_constant_advance_config[`MSCFG_KSH_MSB:`MSCFG_KSH_LSB];
    assign next_adv.bemf_const_value = motor_constant_advance_config[`MSCFG_KVAL_MSB:`MSCFG_KVAL_LSB];
    assign next_adv.advance_mode_select = motor_constant_advance_config[`MSCFG_ADVMODE_BIT];
    assign next_adv.advance_time_shift = motor_constant_advance_config[`MSCFG_ASH_MSB:`MSCFG_ASH_LSB];
    assign next_adv.advance_time_value = motor_constant_advance_config[`MSCFG_AVAL_MSB:`MSCFG_AVAL_LSB];

    // R8 stationary field
    assign next_start.stationary_judge_threshold = startup_brake_config[`MSCFG_STJ_MSB:`MSCFG_STJ_LSB];
    // R9 brake current select
    assign next_start.brake_current_threshold_select = startup_brake_config[`MSCFG_BRKCUR_BIT];
    // R10 hysteresis select
    assign next_start.comparator_hysteresis_select = startup_brake_config[`MSCFG_HYS_BIT];
    // R11 speed detect enable
    assign next_start.initial_speed_detect_enable = startup_brake_config[`MSCFG_ISD_BIT];
    // R12 reverse drive enable
    assign next_start.reverse_drive_enable = startup_brake_config[`MSCFG_REV_BIT];
    // R13 reverse threshold field
    assign next_start.reverse_brake_speed_threshold = startup_brake_config[`MSCFG_REVTHR_MSB:`MSCFG_REVTHR_LSB];
    // R14 R15 open-loop and align current share one field
    assign next_start.open_loop_current_level = startup_brake_config[`MSCFG_OLCUR_MSB:`MSCFG_OLCUR_LSB];
    // R16 ramp rate field
    assign next_start.open_loop_current_ramp = startup_brake_config[`MSCFG_RAMP_MSB:`MSCFG_RAMP_LSB];
    // R17 brake time field
    assign next_start.brake_time_select = startup_brake_config[`MSCFG_BRK_MSB:`MSCFG_BRK_LSB];

    // R8 window doubles per code step
    assign next_stationary = STJ_BASE_CYCLES << next_start.stationary_judge_threshold;
    // R17 brake time halves per step, code zero means no brake
    assign next_brake = (next_start.brake_time_select == 3'h0) ? 32'h0 :
                        (BRK_SLOW_CYCLES >> (next_start.brake_time_select - 3'h1));

    // the engine sees the fields one cycle after the write
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            adv_cfg <= '0;
            start_cfg <= '0;
            brake_active <= 1'b0;
            stationary_cycles <= 32'h0;
            brake_cycles <= 32'h0;
            bank_state <= 8'h00;
        end else begin
            adv_cfg <= next_adv;
            start_cfg <= next_start;
            brake_active <= next_start.brake_time_select != 3'h0;
            stationary_cycles <= next_stationary;
            brake_cycles <= next_brake;
            bank_state <= {5'h00, state};
        end
    end

    // ------------------------------------------------------------
    // scaled constants
    // ------------------------------------------------------------
    // R3 back-EMF constant
    mscfg_shift #(.VW(4), .SW(3), .OW(11)) u_kt (
        .core_clk(core_clk),
        .rstn(rstn),
        .value(next_adv.bemf_const_value),
        .shift(next_adv.bemf_const_shift),
        .scaled(bemf_const)
    );

    // R6 advance time
    mscfg_shift #(.VW(4), .SW(3), .OW(11)) u_adv (
        .core_clk(core_clk),
        .rstn(rstn),
        .value(next_adv.advance_time_value),
        .shift(next_adv.advance_time_shift),
        .scaled(advance_time)
    );

    // ------------------------------------------------------------
    // effective advance time
    // ------------------------------------------------------------
    // back-EMF above supply clamps the margin to zero rather than wrapping
    wire logic [SUPPLY_W-1:0] margin = (bemf_level > supply_level) ? '0 : supply_level - bemf_level;
    wire logic [10+SUPPLY_W:0] product = (11+SUPPLY_W)'(advance_time) * (11+SUPPLY_W)'(margin);
    wire logic [10+SUPPLY_W:0] quotient = (supply_level == '0) ? '0 :
                                          product / (11+SUPPLY_W)'(supply_level);

    // R4 fixed advance / R5 supply-scaled advance
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            advance_time_eff <= 11'h000;
        end else if (adv_cfg.advance_mode_select) begin
            advance_time_eff <= quotient[10:0];
        end else begin
            advance_time_eff <= advance_time;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence wr_adv_s;
        req.wr && hit_adv;
    endsequence

    sequence rd_adv_s;
        req.rd && !req.wr && hit_adv;
    endsequence

    reserved_bit_zero_a: assert property (@(posedge core_clk) disable iff (!rstn) // R2
        motor_constant_advance_config[15] == 1'b0) else $error("reserved bit set");
    reserved_read_zero_a: assert property (@(posedge core_clk) disable iff (!rstn) // R18
        rd_adv_s |=> rvalid && rdata[15] == 1'b0) else $error("reserved bit read back nonzero");
    adv_write_store_a: assert property (@(posedge core_clk) disable iff (!rstn) // R1
        wr_adv_s |=> motor_constant_advance_config == $past(wdata_adv)) else $error("write not stored");
    start_write_store_a: assert property (@(posedge core_clk) disable iff (!rstn) // R7
        req.wr && hit_start |=> startup_brake_config == $past(req.wdata)) else $error("start write lost");
    kt_scale_a: assert property (@(posedge core_clk) disable iff (!rstn) // R3
        wr_adv_s ##1 !req.wr [*2] |-> bemf_const ==
        (11'(motor_constant_advance_config[11:8]) << motor_constant_advance_config[14:12]))
        else $error("back-EMF constant wrong");
    adv_scale_a: assert property (@(posedge core_clk) disable iff (!rstn) // R6
        wr_adv_s ##1 !req.wr [*2] |-> advance_time ==
        (11'(motor_constant_advance_config[3:0]) << motor_constant_advance_config[6:4]))
        else $error("advance time wrong");
    fixed_advance_a: assert property (@(posedge core_clk) disable iff (!rstn) // R4
        !$past(adv_cfg.advance_mode_select) |-> advance_time_eff == $past(advance_time))
        else $error("fixed advance not held");
    brake_off_a: assert property (@(posedge core_clk) disable iff (!rstn) // R17
        req.wr && hit_start && req.wdata[2:0] == 3'h0 |-> ##2 !brake_active && brake_cycles == 32'h0)
        else $error("brake not disabled");
    isd_enable_a: assert property (@(posedge core_clk) disable iff (!rstn) // R11
        req.wr && hit_start |-> ##2 start_cfg.initial_speed_detect_enable == $past(req.wdata[11], 2))
        else $error("speed detect enable mismatch");
    read_latency_a: assert property (@(posedge core_clk) disable iff (!rstn) // R7
        req.rd && !req.wr && hit_start && !$past(req.wr) |=> rdata == startup_brake_config)
        else $error("read data mismatch");
endmodule

// ---- tb/tb_motor_startup_config_regs.sv ----
// self-checking testbench for the start-up configuration register bank
`timescale 1ns/1ps
`include "mscfg_map.svh"
module tb_motor_startup_config_regs;
    // ------------------------------------------------------------
    // signals and design instance
    // ------------------------------------------------------------
    // shortened counts keep stationary and brake figures small in sim
    localparam int STJ = 80;
    localparam int BRK = 2700;
    logic core_clk;
    logic rstn;
    mscfg_pkg::mscfg_req_t req;
    logic [9:0] supply_level;
    logic [9:0] bemf_level;
    logic [15:0] rdata;
    logic rvalid;
    logic ack;
    mscfg_pkg::mscfg_adv_t adv_cfg;
    mscfg_pkg::mscfg_start_t start_cfg;
    logic [10:0] bemf_const;
    logic [10:0] advance_time;
    logic [10:0] advance_time_eff;
    logic brake_active;
    logic [31:0] stationary_cycles;
    logic [31:0] brake_cycles;
    logic [7:0] bank_state;
    int n_fail;
    int checks_done;

    mscfg_regs #(.SUPPLY_W(10), .STJ_BASE_CYCLES(STJ), .BRK_SLOW_CYCLES(BRK)) i_dut (
        .core_clk(core_clk), .rstn(rstn), .req(req), .supply_level(supply_level),
        .bemf_level(bemf_level), .rdata(rdata), .rvalid(rvalid), .ack(ack), .adv_cfg(adv_cfg),
        .start_cfg(start_cfg), .bemf_const(bemf_const), .advance_time(advance_time),
        .advance_time_eff(advance_time_eff), .brake_active(brake_active),
        .stationary_cycles(stationary_cycles), .brake_cycles(brake_cycles), .bank_state(bank_state)
    );

    // 50 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one-cycle write; waits 3 edges after take, past the effective advance that settles 2 edges after take
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        req <= '0;
        #1;
        check(ack, 1'b1);
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    // one-cycle read; answer stands one cycle only, so look right after the take edge
    task automatic reg_read(input logic [7:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge core_clk);
        req <= '0;
        #1;
        check(rvalid, 1'b1);
        check(ack, 1'b1);
        check(rdata, exp);
        // port state shows the read one edge after the take
        @(posedge core_clk);
        #1;
        check(bank_state, 8'h04);
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        reg_read(`MSCFG_ADDR_CONST_ADV, 16'h0000);
        reg_read(`MSCFG_ADDR_START_BRAKE, 16'h0000);
        check(brake_active, 1'b0);
        check(brake_cycles, 32'h0);
        $display("test reset done");
    endtask

    // every shift code with a distinct value, reserved bit 15 always written as one
    task automatic test_const_adv();
        logic [15:0] d;
        logic [3:0] v;
        for (int s = 0; s < 8; s++) begin
            v = 4'(2 * s + 1);
            d = {1'b1, 3'(s), v, 1'b0, 3'(7 - s), 4'(~v)};
            reg_write(`MSCFG_ADDR_CONST_ADV, d);
            check(adv_cfg, d[14:0]);
            check(bemf_const, 11'(v) << s);
            check(advance_time, 11'(4'(~v)) << (7 - s));
            check(advance_time_eff, 11'(4'(~v)) << (7 - s));
            reg_read(`MSCFG_ADDR_CONST_ADV, d & 16'h7FFF);
        end
        $display("test constant and advance done");
    endtask

    // advance scaled by margin over supply, clamped when back-EMF exceeds supply
    task automatic test_adv_mode();
        @(posedge core_clk);
        supply_level <= 10'h190;
        bemf_level <= 10'h064;
        reg_write(`MSCFG_ADDR_CONST_ADV, 16'h00AF);
        check(advance_time, 11'h03C);
        check(advance_time_eff, 11'h02D);
        @(posedge core_clk);
        bemf_level <= 10'h1F4;
        repeat (3) @(posedge core_clk);
        #1;
        check(advance_time_eff, 11'h000);
        $display("test advance mode done");
    endtask

    // every brake code, stationary code and field pattern of the start register
    task automatic test_start_brake();
        logic [15:0] d;
        logic [2:0] c;
        for (int k = 0; k < 8; k++) begin
            c = 3'(k);
            d = {c[1:0], c[0], c[1], c[2], c[0], c[1:0], ~c[1:0], ~c, c};
            reg_write(`MSCFG_ADDR_START_BRAKE, d);
            check(start_cfg, d);
            check(stationary_cycles, STJ << c[1:0]);
            check(brake_active, c != 3'h0);
            check(brake_cycles, (c == 3'h0) ? 32'h0 : BRK >> (c - 3'h1));
            reg_read(`MSCFG_ADDR_START_BRAKE, d);
        end
        $display("test start and brake done");
    endtask

    // writes outside the map leave the bank alone, reads there return zero
    task automatic test_unmapped();
        reg_write(8'h93, 16'hFFFF);
        reg_write(8'h90, 16'hFFFF);
        reg_read(`MSCFG_ADDR_CONST_ADV, 16'h00AF);
        reg_read(8'h93, 16'h0000);
        reg_read(8'h90, 16'h0000);
        $display("test unmapped done");
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        n_fail = 0;
        checks_done = 0;
        rstn = 1'b0;
        req = '0;
        supply_level = 10'h000;
        bemf_level = 10'h000;
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        test_reset();
        test_const_adv();
        test_adv_mode();
        test_start_brake();
        test_unmapped();
        print_verdict();
    end

    // a hang counts as a mismatch and still reaches the closing report
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        print_verdict();
    end
endmodule
